// File: hdl/urg_top.sv
// Purpose: APB register file, status flags and idle timer of the receiver.
// Assumes: Baud clock and lines are synchronous to clk at 25 MHz.
// Notes: pready follows the clock enable, so a frozen block stalls APB.
`timescale 1ns/10ps
module urg_top (
  // Clock, reset and enable.
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [urg_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Serial line.
  input  wire logic                   sck,
  input  wire logic                   rxd,
  output logic                        txd
);
  import urg_pkg::*;

  urg_link_if lk ();

  logic                sck_q;
  logic                tick;
  logic                mapped;
  logic                wr;
  logic                rd;
  logic                cmd_wr;
  logic                sta_rst;
  logic                send_addr;
  logic                wait_cmd;
  logic                reload_cmd;
  logic                thr_wr;
  logic                rhr_rd;
  urg_par_t            par_mode_reg;
  logic                two_stop_reg;
  logic [GUARD_W-1:0]  tx_guard_reg;
  logic [IDLE_W-1:0]   rx_idle_limit_reg;
  logic [DATA_W-1:0]   rx_holding_reg;
  logic [DATA_W-1:0]   tx_holding_reg;
  logic                rx_ready_flag;
  logic                rx_overrun_flag;
  logic                parity_error_flag;
  logic                tx_pend_reg;
  logic                tx_addr_reg;
  logic                addr_pend_reg;
  logic                tx_ready_flag;
  logic                tx_empty_flag;
  logic [IDLE_W-1:0]   idle_cnt_reg;
  logic                idle_run_reg;
  logic                idle_hit;
  logic                timeout_flag;
  logic [31:0]         channel_status_reg;
  logic [31:0]         prdata_next;

  // Engines.
  urg_rx u_rx (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .lk    (lk)
  );

  urg_tx u_tx (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .lk    (lk)
  );

  // Baud clock edge detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q <= 1'b0;
    end else if (ce) begin
      sck_q <= sck;
    end
  end

  assign tick = sck && !sck_q;
  assign lk.bit_tick = tick;
  assign lk.rxd = rxd;
  assign lk.par_mode = par_mode_reg;
  assign lk.two_stop = two_stop_reg;
  assign lk.guard_len = tx_guard_reg;
  assign lk.tx_pend = tx_pend_reg;
  assign lk.tx_data = tx_holding_reg;
  assign lk.tx_addr = tx_addr_reg;
  assign txd = lk.txd;

  // Bus decode.
  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_MODE, ADDR_GUARD, ADDR_IDLE,
      ADDR_STAT, ADDR_RHR, ADDR_THR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && ce && pwrite;
  assign rd = psel && penable && ce && !pwrite;
  assign cmd_wr = wr && paddr == ADDR_CTRL;
  assign sta_rst = cmd_wr && pwdata[CMD_STA_RST_BIT];
  assign send_addr = cmd_wr && pwdata[CMD_SEND_ADDR_BIT];
  assign wait_cmd = cmd_wr && pwdata[CMD_WAIT_BIT];
  assign reload_cmd = cmd_wr && pwdata[CMD_RELOAD_BIT];
  assign thr_wr = wr && paddr == ADDR_THR;
  assign rhr_rd = rd && paddr == ADDR_RHR;

  // Configuration registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      par_mode_reg <= PAR_RST;
      two_stop_reg <= 1'b0;
      tx_guard_reg <= GUARD_RST;
      rx_idle_limit_reg <= IDLE_RST;
    end else if (wr) begin
      if (paddr == ADDR_MODE) begin
        par_mode_reg <= pwdata[2:0];
        two_stop_reg <= pwdata[MODE_STOP2_BIT];
      end
      if (paddr == ADDR_GUARD) begin
        tx_guard_reg <= pwdata[GUARD_W-1:0];
      end
      if (paddr == ADDR_IDLE) begin
        rx_idle_limit_reg <= pwdata[IDLE_W-1:0];
      end
    end
  end

  // Receive holding register and receive flags.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_holding_reg <= '0;
    end else if (ce && lk.rx_done) begin
      rx_holding_reg <= lk.rx_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ready_flag <= 1'b0;
    end else if (ce) begin
      if (lk.rx_done) begin
        rx_ready_flag <= 1'b1;
      end else if (rhr_rd) begin
        rx_ready_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_overrun_flag <= 1'b0;
    end else if (ce) begin
      if (lk.rx_done && rx_ready_flag) begin
        rx_overrun_flag <= 1'b1;
      end else if (sta_rst) begin
        rx_overrun_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parity_error_flag <= 1'b0;
    end else if (ce) begin
      if (lk.rx_done && lk.rx_par_err) begin
        parity_error_flag <= 1'b1;
      end else if (sta_rst) begin
        parity_error_flag <= 1'b0;
      end
    end
  end

  // Transmit holding register and address marking.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_holding_reg <= '0;
      tx_addr_reg <= 1'b0;
    end else if (thr_wr) begin
      tx_holding_reg <= pwdata[DATA_W-1:0];
      tx_addr_reg <= addr_pend_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_pend_reg <= 1'b0;
    end else if (ce) begin
      if (send_addr) begin
        addr_pend_reg <= 1'b1;
      end else if (thr_wr) begin
        addr_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pend_reg <= 1'b0;
    end else if (ce) begin
      if (thr_wr) begin
        tx_pend_reg <= 1'b1;
      end else if (lk.tx_take) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  assign tx_ready_flag = !tx_pend_reg;
  assign tx_empty_flag = !tx_pend_reg && !lk.tx_busy;

  // Receiver idle timer.
  assign idle_hit = idle_run_reg && tick && idle_cnt_reg == 16'h0001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_reg <= '0;
      idle_run_reg <= 1'b0;
    end else if (ce) begin
      if (rx_idle_limit_reg == IDLE_RST) begin
        idle_run_reg <= 1'b0;
      end else if (lk.rx_done || reload_cmd) begin
        idle_cnt_reg <= rx_idle_limit_reg;
        idle_run_reg <= 1'b1;
      end else if (wait_cmd) begin
        idle_run_reg <= 1'b0;
      end else if (idle_run_reg && tick) begin
        idle_cnt_reg <= idle_cnt_reg - 16'h0001;
        if (idle_hit) begin
          idle_run_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_flag <= 1'b0;
    end else if (ce) begin
      if (rx_idle_limit_reg == IDLE_RST) begin
        timeout_flag <= 1'b0;
      end else if (idle_hit) begin
        timeout_flag <= 1'b1;
      end else if (wait_cmd || reload_cmd) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // Status word and read data.
  always_comb begin
    channel_status_reg = '0;
    channel_status_reg[ST_RX_READY] = rx_ready_flag;
    channel_status_reg[ST_TX_READY] = tx_ready_flag;
    channel_status_reg[ST_OVERRUN] = rx_overrun_flag;
    channel_status_reg[ST_PARITY] = parity_error_flag;
    channel_status_reg[ST_TIMEOUT] = timeout_flag;
    channel_status_reg[ST_TX_EMPTY] = tx_empty_flag;
  end

  always_comb begin
    prdata_next = '0;
    case (paddr)
      ADDR_MODE: begin
        prdata_next[2:0] = par_mode_reg;
        prdata_next[MODE_STOP2_BIT] = two_stop_reg;
      end
      ADDR_GUARD: prdata_next[GUARD_W-1:0] = tx_guard_reg;
      ADDR_IDLE: prdata_next[IDLE_W-1:0] = rx_idle_limit_reg;
      ADDR_STAT: prdata_next = channel_status_reg;
      ADDR_RHR: prdata_next[DATA_W-1:0] = rx_holding_reg;
      default: prdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= prdata_next;
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rx_ready_set_a: assert property (ce && lk.rx_done |=> rx_ready_flag)
    else $error("receive-ready not set after character");

  holding_load_a: assert property (
    ce && lk.rx_done |=> rx_holding_reg == $past(lk.rx_data))
    else $error("holding register not loaded");

  overrun_set_a: assert property (
    ce && lk.rx_done && rx_ready_flag |=> rx_overrun_flag)
    else $error("overrun not flagged");

  overrun_clear_a: assert property (
    ce && sta_rst && !(lk.rx_done && rx_ready_flag) |=> !rx_overrun_flag)
    else $error("overrun not cleared by status reset");

  parity_clear_a: assert property (
    ce && sta_rst && !(lk.rx_done && lk.rx_par_err)
    |=> !parity_error_flag)
    else $error("parity error not cleared");

  parity_sticky_a: assert property (
    parity_error_flag && !sta_rst |=> parity_error_flag)
    else $error("parity error dropped without command");

  no_parity_a: assert property (
    ce && lk.rx_done && $past(par_mode_reg) == PAR_NONE
    |-> !lk.rx_par_err)
    else $error("parity error with parity disabled");

  idle_off_a: assert property (
    rx_idle_limit_reg == IDLE_RST && ce |=> !timeout_flag)
    else $error("time-out with limit zero");

  timeout_hit_a: assert property (
    ce && idle_hit && rx_idle_limit_reg != IDLE_RST |=> timeout_flag)
    else $error("time-out flag not raised at zero");

  reload_a: assert property (
    ce && reload_cmd && rx_idle_limit_reg != IDLE_RST
    |=> idle_run_reg && idle_cnt_reg == $past(rx_idle_limit_reg))
    else $error("reload did not restart counter");

  wait_halt_a: assert property (
    ce && wait_cmd && !lk.rx_done && !reload_cmd && !idle_hit
    |=> !idle_run_reg && !timeout_flag)
    else $error("counter runs after wait command");

  tx_ready_rise_a: assert property (
    $rose(tx_ready_flag) |-> $past(lk.tx_take))
    else $error("transmit-ready rose without start bit");

  tx_empty_busy_a: assert property (
    lk.tx_busy |-> !tx_empty_flag)
    else $error("transmitter empty while busy");

  addr_parity_a: assert property (
    lk.tx_take && par_mode_reg[2:1] == 2'h3
    |=> u_tx.par == $past(tx_addr_reg))
    else $error("address mark lost");

  rx_overrun_c: cover property (ce && lk.rx_done && rx_ready_flag);
  rx_parity_c: cover property (ce && lk.rx_done && lk.rx_par_err);
  timeout_c: cover property (ce && idle_hit);
  tx_guard_c: cover property (lk.tx_take && tx_guard_reg != GUARD_RST);
endmodule: urg_top

// File: hdl/urg_pkg.sv
// Purpose: Shared constants, field layout and types of the receiver block.
// Assumes: 32-bit APB data; registers take one aligned word each.
// Notes: Parity codes double as the mode field encoding.
package urg_pkg;
  localparam int DATA_W  = 8;
  localparam int GUARD_W = 8;
  localparam int IDLE_W  = 16;
  localparam int AW      = 8;
  localparam logic [AW-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [AW-1:0] ADDR_MODE  = 8'h04;
  localparam logic [AW-1:0] ADDR_GUARD = 8'h08;
  localparam logic [AW-1:0] ADDR_IDLE  = 8'h0C;
  localparam logic [AW-1:0] ADDR_STAT  = 8'h10;
  localparam logic [AW-1:0] ADDR_RHR   = 8'h14;
  localparam logic [AW-1:0] ADDR_THR   = 8'h18;
  localparam int CMD_STA_RST_BIT = 0;
  localparam int CMD_SEND_ADDR_BIT = 1;
  localparam int CMD_WAIT_BIT = 2;
  localparam int CMD_RELOAD_BIT = 3;
  localparam int MODE_STOP2_BIT = 3;
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_PARITY = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_TX_EMPTY = 5;
  typedef logic [2:0] urg_par_t;
  localparam urg_par_t PAR_EVEN  = 3'h0;
  localparam urg_par_t PAR_ODD   = 3'h1;
  localparam urg_par_t PAR_SPACE = 3'h2;
  localparam urg_par_t PAR_MARK  = 3'h3;
  localparam urg_par_t PAR_NONE  = 3'h4;
  localparam urg_par_t PAR_RST   = PAR_NONE;
  localparam logic [GUARD_W-1:0] GUARD_RST = 8'h00;
  localparam logic [IDLE_W-1:0]  IDLE_RST  = 16'h0000;
  typedef enum {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} urg_rx_st_t;
  typedef enum {TX_IDLE, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} urg_tx_st_t;

  // Parity bit the line should carry for a character in a given mode.
  function automatic logic urg_par_bit(input urg_par_t m,
                                       input logic [DATA_W-1:0] d,
                                       input logic addr);
    logic p;
    p = addr;
    case (m)
      PAR_EVEN:  p = ^d;
      PAR_ODD:   p = ~(^d);
      PAR_SPACE: p = 1'b0;
      PAR_MARK:  p = 1'b1;
      default:   p = addr;
    endcase
    return p;
  endfunction: urg_par_bit
endpackage: urg_pkg

// File: hdl/urg_link_if.sv
// Purpose: Bundle between the register logic and the two serial engines.
// Assumes: One clock; bit_tick marks a rising baud clock edge.
// Notes: The control side drives its signals hierarchically.
`timescale 1ns/10ps
interface urg_link_if;
  import urg_pkg::*;
  logic              bit_tick;
  logic              rxd;
  urg_par_t          par_mode;
  logic              two_stop;
  logic [GUARD_W-1:0] guard_len;
  logic              rx_done;
  logic [DATA_W-1:0] rx_data;
  logic              rx_par_err;
  logic              tx_pend;
  logic [DATA_W-1:0] tx_data;
  logic              tx_addr;
  logic              tx_take;
  logic              tx_busy;
  logic              txd;
  modport rx (input bit_tick, rxd, par_mode, two_stop,
              output rx_done, rx_data, rx_par_err);
  modport tx (input bit_tick, par_mode, two_stop, guard_len, tx_pend,
              tx_data, tx_addr, output tx_take, tx_busy, txd);
endinterface: urg_link_if

// File: hdl/urg_rx.sv
// Purpose: Synchronous receive shifter with parity check.
// Assumes: Line and baud tick are synchronous to clk.
// Notes: Data arrives least significant bit first.
`timescale 1ns/10ps
module urg_rx (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Engine link.
  urg_link_if.rx   lk
);
  import urg_pkg::*;
  localparam int CW = $clog2(DATA_W);
  urg_rx_st_t        st;
  logic [DATA_W-1:0] sh;
  logic [CW-1:0]     cnt;
  logic              par_q;
  logic              sc;
  logic              last;
  logic              err;

  assign last = ce && lk.bit_tick && st == RX_STOP && sc == lk.two_stop;

  always_comb begin
    if (lk.par_mode == PAR_NONE) begin
      err = 1'b0;
    end else if (lk.par_mode[2] && lk.par_mode[1]) begin
      err = par_q;
    end else begin
      err = par_q != urg_par_bit(lk.par_mode, sh, 1'b0);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= RX_IDLE;
      sh <= '0;
      cnt <= '0;
      par_q <= 1'b0;
      sc <= 1'b0;
    end else if (ce && lk.bit_tick) begin
      case (st)
        RX_IDLE: begin
          if (!lk.rxd) begin
            st <= RX_DATA;
            cnt <= '0;
          end
        end
        RX_DATA: begin
          sh <= {lk.rxd, sh[DATA_W-1:1]};
          cnt <= cnt + 1'b1;
          sc <= 1'b0;
          if (cnt == CW'(DATA_W - 1)) begin
            st <= (lk.par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          par_q <= lk.rxd;
          st <= RX_STOP;
        end
        RX_STOP: begin
          if (sc == lk.two_stop) begin
            st <= RX_IDLE;
          end else begin
            sc <= 1'b1;
          end
        end
        default: st <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lk.rx_done <= 1'b0;
      lk.rx_data <= '0;
      lk.rx_par_err <= 1'b0;
    end else if (ce) begin
      lk.rx_done <= last;
      if (last) begin
        lk.rx_data <= sh;
        lk.rx_par_err <= err;
      end
    end
  end
endmodule: urg_rx

// File: hdl/urg_tx.sv
// Purpose: Transmit shifter with parity and guard gap.
// Assumes: Bits change on the rising baud clock edge.
// Notes: tx_busy covers the whole character including the guard.
`timescale 1ns/10ps
module urg_tx (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Engine link.
  urg_link_if.tx   lk
);
  import urg_pkg::*;
  localparam int CW = $clog2(DATA_W);
  urg_tx_st_t         st;
  logic [DATA_W-1:0]  sh;
  logic [CW-1:0]      cnt;
  logic [GUARD_W-1:0] gcnt;
  logic               par;
  logic               sc;
  logic               hold;
  logic               tick;

  assign tick = ce && lk.bit_tick;
  assign lk.tx_take = tick && st == TX_IDLE && lk.tx_pend;
  assign lk.tx_busy = st != TX_IDLE || hold;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 1'b0;
    end else if (tick) begin
      hold <= st != TX_IDLE || lk.tx_pend;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= TX_IDLE;
      lk.txd <= 1'b1;
      sh <= '0;
      cnt <= '0;
      gcnt <= '0;
      par <= 1'b0;
      sc <= 1'b0;
    end else if (tick) begin
      case (st)
        TX_IDLE: begin
          lk.txd <= !lk.tx_pend;
          if (lk.tx_pend) begin
            sh <= lk.tx_data;
            par <= urg_par_bit(lk.par_mode, lk.tx_data, lk.tx_addr);
            cnt <= '0;
            st <= TX_DATA;
          end
        end
        TX_DATA: begin
          lk.txd <= sh[cnt];
          cnt <= cnt + 1'b1;
          sc <= 1'b0;
          if (cnt == CW'(DATA_W - 1)) begin
            st <= (lk.par_mode == PAR_NONE) ? TX_STOP : TX_PAR;
          end
        end
        TX_PAR: begin
          lk.txd <= par;
          st <= TX_STOP;
        end
        TX_STOP: begin
          lk.txd <= 1'b1;
          sc <= 1'b1;
          gcnt <= '0;
          if (sc == lk.two_stop) begin
            st <= (lk.guard_len == GUARD_RST) ? TX_IDLE : TX_GUARD;
          end
        end
        TX_GUARD: begin
          lk.txd <= 1'b1;
          gcnt <= gcnt + 1'b1;
          if (gcnt == lk.guard_len - 8'h01) begin
            st <= TX_IDLE;
          end
        end
        default: st <= TX_IDLE;
      endcase
    end
  end
endmodule: urg_tx

// File: testbench/urg_remote.sv
// Purpose: Remote serial device on the receive and transmit lines.
// Assumes: The baud clock runs free; bits change on its falling edge.
// Notes: The line rests high between characters.
`timescale 1ns/10ps
module urg_remote (
  // Clock and lines.
  input  wire logic clk,
  output logic      sck,
  output logic      rxd,
  input  wire logic txd
);
  logic [1:0] div_reg;
  initial begin
    div_reg = 2'h0;
    sck = 1'b0;
    rxd = 1'b1;
  end
  always @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
    sck <= div_reg[1];
  end
  // Sends start, data, optional parity and one stop bit.
  task automatic send(input logic [7:0] d, input logic p, input logic u);
    @(negedge sck) rxd <= 1'b0;
    for (int i = 0; i < 8; i++) @(negedge sck) rxd <= d[i];
    if (u) @(negedge sck) rxd <= p;
    @(negedge sck) rxd <= 1'b1;
    @(negedge sck);
  endtask: send
  // Captures data and parity of the next transmitted character.
  task automatic grab(output logic [8:0] f);
    do @(negedge sck); while (txd !== 1'b0);
    for (int i = 0; i < 9; i++) @(negedge sck) f[i] = txd;
  endtask: grab
endmodule: urg_remote

// File: testbench/urg_rx_parity_guard_timeout_tb_top.sv
// Purpose: Self-checking bench of the receiver block.
// Assumes: The APB master waits for pready; clock enable drops once.
// Notes: Status reads expect tx_ready and tx_empty high when idle.
`timescale 1ns/10ps
module urg_rx_parity_guard_timeout_tb_top;
  import urg_pkg::*;
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, sck, rxd, txd;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata;
  int            fails, checks, cyc;
  urg_top i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck),
    .rxd(rxd), .txd(txd));
  urg_remote i_rem (.clk(clk), .sck(sck), .rxd(rxd), .txd(txd));
  always #20 clk = ~clk;
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask: test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, s, x);
    end
  endtask: chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask: apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask: wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask: rdc
  task automatic t_parity;
    logic [5:0] tb [9] = '{6'h02, 6'h07, 6'h0E, 6'h0B, 6'h1B, 6'h17,
                           6'h26, 6'h37, 6'h3A};
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_MODE, {29'h0, tb[i][5:3]});
      i_rem.send(8'h41, tb[i][2], tb[i][1]);
      repeat (4) @(posedge clk);
      rdc(ADDR_STAT, 32'h23 | {28'h0, tb[i][0], 3'h0});
      rdc(ADDR_RHR, 32'h41);
      wr(ADDR_CTRL, 32'h1);
      rdc(ADDR_STAT, 32'h22);
    end
  endtask: t_parity
  task automatic t_overrun;
    wr(ADDR_MODE, 32'h4);
    i_rem.send(8'h11, 1'b0, 1'b0);
    i_rem.send(8'h22, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rdc(ADDR_STAT, 32'h27);
    rdc(ADDR_RHR, 32'h22);
    wr(ADDR_CTRL, 32'h1);
    rdc(ADDR_STAT, 32'h22);
  endtask: t_overrun
  task automatic t_timeout;
    wr(ADDR_IDLE, 32'h5);
    wr(ADDR_CTRL, 32'h8);
    rdc(ADDR_STAT, 32'h22);
    repeat (40) @(posedge clk);
    rdc(ADDR_STAT, 32'h32);
    wr(ADDR_CTRL, 32'h8);
    wr(ADDR_CTRL, 32'h4);
    repeat (60) @(posedge clk);
    rdc(ADDR_STAT, 32'h22);
    i_rem.send(8'h5A, 1'b0, 1'b0);
    rdc(ADDR_RHR, 32'h5A);
    repeat (40) @(posedge clk);
    rdc(ADDR_STAT, 32'h32);
    wr(ADDR_CTRL, 32'h8);
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    ce <= 1'b1;
    rdc(ADDR_STAT, 32'h22);
    repeat (40) @(posedge clk);
    rdc(ADDR_STAT, 32'h32);
    wr(ADDR_IDLE, 32'h0);
    wr(ADDR_CTRL, 32'h8);
    repeat (40) @(posedge clk);
    rdc(ADDR_STAT, 32'h22);
  endtask: t_timeout
  task automatic t_tx;
    logic [8:0] f;
    wr(ADDR_MODE, 32'h6);
    wr(ADDR_GUARD, 32'h2);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_THR, 32'hA5);
    i_rem.grab(f);
    chk({23'h0, f}, 32'h1A5);
    wr(ADDR_THR, 32'h5A);
    rdc(ADDR_STAT, 32'h00);
    rdc(ADDR_STAT, 32'h00);
    i_rem.grab(f);
    chk({23'h0, f}, 32'h05A);
    rdc(ADDR_STAT, 32'h02);
    repeat (30) @(posedge clk);
    rdc(ADDR_STAT, 32'h22);
  endtask: t_tx
  initial begin : main
    logic [31:0] q;
    logic e;
    {clk, rst_b, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    ce <= 1'b1;
    rdc(ADDR_STAT, 32'h22);
    t_parity;
    t_overrun;
    t_timeout;
    t_tx;
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    test_done;
  end
endmodule: urg_rx_parity_guard_timeout_tb_top
